// [meid_injector.sv]
`timescale 1ns/1ps
`default_nettype none
`include "meid_defines.svh"
module meid_injector
   import meid_pkg::*;
(
   // Clock and reset
   input  wire logic          mclk_in,
   input  wire logic          resetn_in,
   // Configuration
   input  wire logic          three_modules_per_channel_in,
   // Configuration dword access
   input  wire meid_cfg_req_t cfg_in,
   output var  logic [31:0]   cfg_rdata_out,
   output var  logic          cfg_rvalid_out,
   // Write path from channel
   input  wire logic          wr_valid_in,
   input  wire meid_wr_req_t  wr_in,
   // Write path toward modules
   output var  logic          wr_valid_out,
   output var  meid_wr_out_t  wr_out
);

   // Programmed state
   logic [41:0] match;
   logic [31:0] check_bit_flip_mask;
   logic [4:0]  control;
   logic [15:0] ecc_count;
   logic [15:0] parity_count;

   // Decoded control fields
   wire logic       ctl_parity  = control[`MEID_CTL_PARITY];
   wire logic       ctl_ecc     = control[`MEID_CTL_ECC];
   wire logic       ctl_repeat  = control[`MEID_CTL_REPEAT];
   wire meid_half_t ctl_half    = meid_half_t'(control[`MEID_CTL_HALF_HI:`MEID_CTL_HALF_LO]);

   // Module and rank field split depends on population
   wire logic [1:0] want_module;
   wire logic [1:0] want_rank;
   wire logic [1:0] got_module;
   wire logic [1:0] got_rank;

   assign want_module = three_modules_per_channel_in
                        ? match[`MEID_MODULE_BIT:`MEID_RANK_HI]
                        : {1'b0, match[`MEID_MODULE_BIT]}; // [R3]
   assign want_rank   = three_modules_per_channel_in
                        ? {1'b0, match[`MEID_RANK_LO]}
                        : match[`MEID_RANK_HI:`MEID_RANK_LO]; // [R3]
   assign got_module  = three_modules_per_channel_in
                        ? wr_in.module_sel
                        : {1'b0, wr_in.module_sel[0]};
   assign got_rank    = three_modules_per_channel_in
                        ? {1'b0, wr_in.rank[0]}
                        : wr_in.rank;

   // Field comparators
   wire logic hit_module;
   wire logic hit_rank;
   wire logic hit_bank;
   wire logic hit_page;
   wire logic hit_column;

   meid_field_match #(.W(2)) u_match_module
   (
      .field_in  (got_module),
      .want_in   (want_module),
      .ignore_in (match[`MEID_IGN_MODULE]),
      .hit_out   (hit_module)
   );

   meid_field_match #(.W(2)) u_match_rank
   (
      .field_in  (got_rank),
      .want_in   (want_rank),
      .ignore_in (match[`MEID_IGN_RANK]),
      .hit_out   (hit_rank)
   );

   meid_field_match #(.W(4)) u_match_bank
   (
      .field_in  (wr_in.bank),
      .want_in   (match[`MEID_BANK_HI:`MEID_BANK_LO]),
      .ignore_in (match[`MEID_IGN_BANK]),
      .hit_out   (hit_bank)
   );

   meid_field_match #(.W(16)) u_match_page
   (
      .field_in  (wr_in.page),
      .want_in   (match[`MEID_PAGE_HI:`MEID_PAGE_LO]),
      .ignore_in (match[`MEID_IGN_PAGE]),
      .hit_out   (hit_page)
   );

   meid_field_match #(.W(14)) u_match_column
   (
      .field_in  (wr_in.column),
      .want_in   (match[`MEID_COLUMN_HI:`MEID_COLUMN_LO]),
      .ignore_in (match[`MEID_IGN_COLUMN]),
      .hit_out   (hit_column)
   );

   // One match decision per write, shared by both kinds of injection
   wire logic addr_hit;
   wire logic write_hit;
   wire logic do_ecc;
   wire logic do_parity;

   assign addr_hit  = hit_module & hit_rank & hit_bank & hit_page & hit_column; // [R1] [R18]
   assign write_hit = wr_valid_in & wr_in.is_write & addr_hit; // [R15] [R16]
   assign do_ecc    = write_hit & ctl_ecc; // [R7] [R14]
   assign do_parity = write_hit & ctl_parity; // [R9] [R14]

   // Mask placement per half; the same 32-bit mask serves either half
   wire logic [31:0] flip_lower;
   wire logic [31:0] flip_upper;
   wire logic [63:0] flipped_bits;

   assign flip_lower = (do_ecc && (ctl_half == MEID_HALF_LOWER || ctl_half == MEID_HALF_FULL))
                       ? check_bit_flip_mask : 32'h0000_0000; // [R10]
   assign flip_upper = (do_ecc && (ctl_half == MEID_HALF_UPPER || ctl_half == MEID_HALF_FULL))
                       ? check_bit_flip_mask : 32'h0000_0000; // [R10]
   // Plain XOR: mask pattern alone decides correctable or not
   assign flipped_bits = wr_in.check_bits ^ {flip_upper, flip_lower}; // [R4] [R5] [R6]

   // Register access decode
   wire logic wr_match_lo  = cfg_in.wr && cfg_in.addr == `MEID_OFS_MATCH_LO;
   wire logic wr_match_hi  = cfg_in.wr && cfg_in.addr == `MEID_OFS_MATCH_HI;
   wire logic wr_flip_mask = cfg_in.wr && cfg_in.addr == `MEID_OFS_FLIP_MASK;
   wire logic wr_control   = cfg_in.wr && cfg_in.addr == `MEID_OFS_CONTROL;

   // Self-clear of enables; a software write in the same cycle wins
   wire logic [4:0] next_control;
   wire logic       clear_ecc;
   wire logic       clear_parity;

   assign clear_ecc    = do_ecc & ~ctl_repeat; // [R8] [R11]
   assign clear_parity = do_parity & ~ctl_repeat; // [R9] [R11]
   assign next_control = wr_control ? cfg_in.wdata[4:0] // [R12] [R13]
                         : {ctl_parity & ~clear_parity,
                            ctl_ecc & ~clear_ecc,
                            control[`MEID_CTL_HALF_HI:`MEID_CTL_REPEAT]};

   // Read multiplexer
   wire logic [31:0] rd_value;

   assign rd_value = (cfg_in.addr == `MEID_OFS_MATCH_LO)  ? match[31:0] :
                     (cfg_in.addr == `MEID_OFS_MATCH_HI)  ? {22'h00_0000, match[41:32]} :
                     (cfg_in.addr == `MEID_OFS_FLIP_MASK) ? check_bit_flip_mask :
                     (cfg_in.addr == `MEID_OFS_CONTROL)   ? {27'h000_0000, control} :
                     (cfg_in.addr == `MEID_OFS_STATUS)    ? {parity_count, ecc_count} :
                     32'h0000_0000;

   // Programmed registers
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         match               <= `MEID_MATCH_RESET;
         check_bit_flip_mask <= `MEID_MASK_RESET;
         control             <= `MEID_CTL_RESET;
      end
      else
      begin
         if (wr_match_lo)
            match[31:0] <= cfg_in.wdata;
         if (wr_match_hi)
            match[41:32] <= cfg_in.wdata[9:0];
         if (wr_flip_mask)
            check_bit_flip_mask <= cfg_in.wdata;
         control <= next_control;
      end
   end

   // Injection counters, wrap silently; cleared by any control write
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ecc_count    <= 16'h0000;
         parity_count <= 16'h0000;
      end
      else if (wr_control)
      begin
         ecc_count    <= 16'h0000;
         parity_count <= 16'h0000;
      end
      else
      begin
         ecc_count    <= ecc_count + 16'(do_ecc);
         parity_count <= parity_count + 16'(do_parity);
      end
   end

   // Read data, one cycle after the request
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cfg_rdata_out  <= 32'h0000_0000;
         cfg_rvalid_out <= 1'b0;
      end
      else
      begin
         cfg_rdata_out  <= cfg_in.rd ? rd_value : 32'h0000_0000;
         cfg_rvalid_out <= cfg_in.rd;
      end
   end

   // Write path stage; reads pass with check bits untouched
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wr_valid_out <= 1'b0;
         wr_out       <= '0;
      end
      else
      begin
         wr_valid_out           <= wr_valid_in;
         wr_out.is_write        <= wr_in.is_write;
         wr_out.check_bits      <= flipped_bits; // [R15]
         wr_out.addr_parity_err <= do_parity; // [R9]
         wr_out.ecc_injected    <= do_ecc; // [R7]
      end
   end

endmodule // meid_injector
`default_nettype wire

// [meid_defines.svh]
// Operation
// [R1] Compare each write's bank, page, column, module, rank against programmed match fields.
// [R2] Bits 41..37 ignore module, rank, bank, page, column; ignored field always matches.
// [R3] One/two modules: bit 36 module, 35:34 rank; three modules: 36:35 module, 34 rank.
// [R4] A 32-bit check-bit flip mask inverts each selected check bit of a written half.
// [R5] One bit, or bits within one aligned symbol pair, give a correctable error.
// [R6] Bits in two different symbol pairs give an uncorrectable error.
// [R7] Without ECC inject enable at bit 3, no check bit is ever corrupted.
// [R8] Without repeat, ECC inject enable clears itself after the first injection.
// [R9] Bit 4 forces address parity error on a match; self-clears unless repeat is on.
// [R10] Half select: 11 full line, 10 upper half, 01 lower half, 00 no masking.
// [R11] With repeat bit 0 set, every matching write is injected until software clears it.
// [R12] Software programs match and mask first, then control with repeat and half select.
// [R13] Writing zero to control stops all ECC and parity injection.
// [R14] Parity and ECC injection run alone or together, sharing one match setting.
// [R15] Only writes are injected; reads pass through untouched.
// [R16] Software must issue writes to the matched address for any injection.
// [R17] Injecting writes must reach memory, not stay in caches.
// [R18] Match is evaluated per write with the decoded address used to issue it.
`ifndef MEID_DEFINES_SVH
`define MEID_DEFINES_SVH

// Configuration dword offsets
`define MEID_OFS_MATCH_LO    8'hf0
`define MEID_OFS_MATCH_HI    8'hf4
`define MEID_OFS_FLIP_MASK   8'hf8
`define MEID_OFS_CONTROL     8'hfc
`define MEID_OFS_STATUS      8'hec

// Address match fields
`define MEID_IGN_MODULE      41
`define MEID_IGN_RANK        40
`define MEID_IGN_BANK        39
`define MEID_IGN_PAGE        38
`define MEID_IGN_COLUMN      37
`define MEID_MODULE_BIT      36
`define MEID_RANK_HI         35
`define MEID_RANK_LO         34
`define MEID_BANK_HI         33
`define MEID_BANK_LO         30
`define MEID_PAGE_HI         29
`define MEID_PAGE_LO         14
`define MEID_COLUMN_HI       13
`define MEID_COLUMN_LO       0

// Control fields
`define MEID_CTL_PARITY      4
`define MEID_CTL_ECC         3
`define MEID_CTL_HALF_HI     2
`define MEID_CTL_HALF_LO     1
`define MEID_CTL_REPEAT      0

// Reset values
`define MEID_MATCH_RESET     42'h000_0000_0000
`define MEID_MASK_RESET      32'h0000_0000
`define MEID_CTL_RESET       5'h00

`endif

// [meid_pkg.sv]
`default_nettype none
package meid_pkg;

   typedef enum logic [1:0]
   {
      MEID_HALF_NONE  = 2'h0,
      MEID_HALF_LOWER = 2'h1,
      MEID_HALF_UPPER = 2'h2,
      MEID_HALF_FULL  = 2'h3
   } meid_half_t;

   typedef struct packed
   {
      logic        is_write;
      logic [1:0]  module_sel;
      logic [1:0]  rank;
      logic [3:0]  bank;
      logic [15:0] page;
      logic [13:0] column;
      logic [63:0] check_bits;
   } meid_wr_req_t;

   typedef struct packed
   {
      logic        is_write;
      logic [63:0] check_bits;
      logic        addr_parity_err;
      logic        ecc_injected;
   } meid_wr_out_t;

   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } meid_cfg_req_t;

endpackage
`default_nettype wire

// [meid_field_match.sv]
`timescale 1ns/1ps
`default_nettype none
module meid_field_match
#(
   parameter int W = 4
)
(
   // Compare
   input  wire logic [W-1:0] field_in,
   input  wire logic [W-1:0] want_in,
   input  wire logic         ignore_in,
   // Result
   output wire logic         hit_out
);

   assign hit_out = ignore_in | (field_in == want_in); // [R2]

endmodule // meid_field_match
`default_nettype wire

// [meid_injector_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module meid_injector_chk
   import meid_pkg::*;
(
   // Clock and reset
   input wire logic          mclk_in,
   input wire logic          resetn_in,
   // Watched ports
   input wire logic          three_modules_per_channel_in,
   input wire meid_cfg_req_t cfg_in,
   input wire logic [31:0]   cfg_rdata_out,
   input wire logic          cfg_rvalid_out,
   input wire logic          wr_valid_in,
   input wire meid_wr_req_t  wr_in,
   input wire logic          wr_valid_out,
   input wire meid_wr_out_t  wr_out
);
   logic [2:0] ctl_q;
   wire        ctl_wr = cfg_in.wr & (cfg_in.addr == 8'hfc);
   // Mirrors half select and repeat; self-clear never touches them
   always_ff @(posedge mclk_in or negedge resetn_in)
      if (!resetn_in)
         ctl_q <= 3'h0;
      else if (ctl_wr)
         ctl_q <= cfg_in.wdata[2:0];
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence ecc_shot;
      wr_valid_in && !ctl_q[0] && !ctl_wr ##1 wr_out.ecc_injected && wr_valid_in && !ctl_wr;
   endsequence
   sequence par_shot;
      wr_valid_in && !ctl_q[0] && !ctl_wr ##1 wr_out.addr_parity_err && wr_valid_in && !ctl_wr;
   endsequence
   sequence ctl_zero;
      ctl_wr && cfg_in.wdata[4:3] == 2'h0 ##1 wr_valid_in;
   endsequence
   read_pass_a: assert property (wr_valid_in && !wr_in.is_write |=>
      !wr_out.ecc_injected && !wr_out.addr_parity_err && wr_out.check_bits == $past(wr_in.check_bits))
      else $error("read transaction altered");
   ctl_off_a: assert property (ctl_zero |=> !wr_out.ecc_injected && !wr_out.addr_parity_err)
      else $error("injection after control cleared");
   ecc_gate_a: assert property (wr_valid_in |=>
      wr_out.ecc_injected || wr_out.check_bits == $past(wr_in.check_bits))
      else $error("check bits flipped without injection");
   upper_keep_a: assert property (wr_valid_in && !ctl_q[2] |=>
      wr_out.check_bits[63:32] == $past(wr_in.check_bits[63:32])) else $error("upper half flipped");
   lower_keep_a: assert property (wr_valid_in && !ctl_q[1] |=>
      wr_out.check_bits[31:0] == $past(wr_in.check_bits[31:0])) else $error("lower half flipped");
   full_same_a: assert property (wr_valid_in && ctl_q[2:1] == 2'h3 |=>
      (wr_out.check_bits[63:32] ^ $past(wr_in.check_bits[63:32]))
      == (wr_out.check_bits[31:0] ^ $past(wr_in.check_bits[31:0]))) else $error("halves differ");
   ecc_once_a: assert property (ecc_shot |=> !wr_out.ecc_injected)
      else $error("one-shot ecc injected twice");
   par_once_a: assert property (par_shot |=> !wr_out.addr_parity_err)
      else $error("one-shot parity injected twice");
   idle_flag_a: assert property (!wr_valid_out |->
      !wr_out.ecc_injected && !wr_out.addr_parity_err) else $error("flag without transaction");
   rd_pulse_a: assert property (cfg_rvalid_out == $past(cfg_in.rd))
      else $error("read valid not one cycle after read");
   rd_idle_a: assert property (!cfg_rvalid_out |-> cfg_rdata_out == 32'h0000_0000)
      else $error("read data not zero while idle");
endmodule // meid_injector_chk
bind meid_injector meid_injector_chk u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
   .three_modules_per_channel_in(three_modules_per_channel_in), .cfg_in(cfg_in),
   .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .wr_valid_in(wr_valid_in),
   .wr_in(wr_in), .wr_valid_out(wr_valid_out), .wr_out(wr_out));
`default_nettype wire

// [meid_dimm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module meid_dimm_model
   import meid_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk_in,
   input  wire logic         resetn_in,
   // From the injector
   input  wire logic         wr_valid_in,
   input  wire meid_wr_out_t wr_in,
   // Committed words
   output var  logic         seen_valid_out,
   output var  meid_wr_out_t seen_out
);
   // Every transaction is committed, nothing held back in a cache
   always_ff @(posedge mclk_in or negedge resetn_in)
      if (!resetn_in)
      begin
         seen_valid_out <= 1'b0;
         seen_out       <= '0;
      end
      else
      begin
         seen_valid_out <= wr_valid_in;
         seen_out       <= wr_in;
      end
endmodule // meid_dimm_model
`default_nettype wire

// [meid_injector_test.sv]
`timescale 1ns/1ps
`default_nettype none
module meid_injector_test
   import meid_pkg::*;
;
   logic          mclk_in   = 1'b0;
   logic          resetn_in = 1'b0;
   logic          tm        = 1'b0;
   logic          vin       = 1'b0;
   logic          rvalid, vout, seen_v;
   logic [31:0]   rdata;
   meid_cfg_req_t cfg       = '0;
   meid_wr_req_t  req       = '0;
   meid_wr_out_t  wout, seen_w;
   logic [41:0]   sh_match  = '0;
   logic [31:0]   sh_mask   = '0;
   logic [4:0]    sh_ctl    = '0;
   logic [15:0]   rnd       = 16'h71a3;
   logic [15:0]   sh_ecc    = '0;
   logic [15:0]   sh_par    = '0;
   logic [7:0]    ofs[6]    = '{8'hf0, 8'hf4, 8'hf8, 8'hfc, 8'hec, 8'h40};
   logic [4:0]    ctl[8]    = '{5'h0e, 5'h06, 5'h13, 5'h1b, 5'h1d, 5'h09, 5'h18, 5'h00};
   meid_wr_out_t  wq[$];
   logic [31:0]   rq[$];
   int            error_cnt = 0;
   int            cmp_count = 0;
   int            cycles    = 0;
   initial forever #25 mclk_in = ~mclk_in;
   meid_injector dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .three_modules_per_channel_in(tm), .cfg_in(cfg), .cfg_rdata_out(rdata),
      .cfg_rvalid_out(rvalid), .wr_valid_in(vin), .wr_in(req), .wr_valid_out(vout), .wr_out(wout));
   meid_dimm_model u_dimm (.mclk_in(mclk_in), .resetn_in(resetn_in), .wr_valid_in(vout),
      .wr_in(wout), .seen_valid_out(seen_v), .seen_out(seen_w));
   function automatic logic hit(input meid_wr_req_t r, input logic [41:0] m);
      logic mr;
      mr = tm ? (m[41] | r.module_sel == m[36:35]) & (m[40] | r.rank[0] == m[34])
              : (m[41] | r.module_sel[0] == m[36]) & (m[40] | r.rank == m[35:34]);
      return mr & (m[39] | r.bank == m[33:30]) & (m[38] | r.page == m[29:14])
         & (m[37] | r.column == m[13:0]);
   endfunction
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic mk(output meid_wr_req_t r);
      rnd = lfsr(rnd);
      r = {rnd[0] | rnd[1], rnd[3:2], rnd[5:4], rnd[9:6], {2{rnd[15:8]}}, rnd[13:0], {4{rnd}}};
      if (rnd[11] | rnd[12])
         {r.bank, r.page, r.column} = sh_match[33:0]; // Aimed at the target
      if (rnd[11] | rnd[12])
         {r.module_sel, r.rank} = tm ? {sh_match[36:35], rnd[5], sh_match[34]}
                                     : {rnd[4], sh_match[36:34]};
   endtask
   task automatic wr_cycle(input meid_wr_req_t r);
      meid_wr_out_t e;
      logic         h;
      @(posedge mclk_in);
      #1;
      cfg = '0;
      vin = 1'b1;
      req = r;
      h = r.is_write & hit(r, sh_match);
      e.is_write = r.is_write;
      e.check_bits = r.check_bits ^ ((h & sh_ctl[3]) ? {sh_ctl[2] ? sh_mask : 32'h0,
         sh_ctl[1] ? sh_mask : 32'h0} : 64'h0);
      e.addr_parity_err = h & sh_ctl[4];
      e.ecc_injected = h & sh_ctl[3];
      wq.push_back(e);
      sh_ecc += 16'(e.ecc_injected);
      sh_par += 16'(e.addr_parity_err);
      if (h & ~sh_ctl[0])
         sh_ctl[4:3] = 2'h0;
   endtask
   task automatic cfg_cycle(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      #1;
      vin = 1'b0;
      cfg = '{wr: w, rd: r, addr: a, wdata: d};
      if (r)
         rq.push_back(a == 8'hf0 ? sh_match[31:0] : a == 8'hf4 ? {22'h0, sh_match[41:32]}
            : a == 8'hf8 ? sh_mask : a == 8'hfc ? {27'h0, sh_ctl}
            : a == 8'hec ? {sh_par, sh_ecc} : 32'h0);
      if (w && a == 8'hf0)
         sh_match[31:0] = d;
      if (w && a == 8'hf4)
         sh_match[41:32] = d[9:0];
      if (w && a == 8'hf8)
         sh_mask = d;
      if (w && a == 8'hfc)
      begin
         sh_ctl = d[4:0];
         sh_ecc = 16'h0000;
         sh_par = 16'h0000;
      end
   endtask
   task automatic cmp_word(input meid_wr_out_t e, input meid_wr_out_t g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value write word expected %h seen %h", e, g);
      end
   endtask
   task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value read data expected %h seen %h", e, g);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(negedge mclk_in)
   begin
      if (seen_v === 1'b1)
         cmp_word(wq.size() ? wq.pop_front() : '1, seen_w);
      if (rvalid === 1'b1)
         cmp_data(rq.size() ? rq.pop_front() : '1, rdata);
   end
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   initial
   begin
      meid_wr_req_t r;
      repeat (12) @(posedge mclk_in);
      #1 resetn_in = 1'b1;
      foreach (ofs[i])
         cfg_cycle(1'b0, 1'b1, ofs[i], 32'h0); // Reset values, unmapped reads zero
      cfg_cycle(1'b1, 1'b0, 8'hf0, 32'h8123_4567);
      cfg_cycle(1'b1, 1'b0, 8'hf4, 32'h0000_001d);
      cfg_cycle(1'b1, 1'b0, 8'hf8, 32'h0000_0180);
      for (int i = 0; i < 10; i++)
      begin
         tm = i > 3;
         if (i == 8)
            cfg_cycle(1'b1, 1'b0, 8'hf4, 32'h0000_03e0);
         if (i == 8)
            cfg_cycle(1'b1, 1'b0, 8'hf8, 32'h00ff_ff00);
         cfg_cycle(1'b1, 1'b0, 8'hfc, {27'h0, i < 8 ? ctl[i] : 5'h1f});
         repeat (6)
         begin
            mk(r);
            wr_cycle(r);
         end
         foreach (ofs[k])
            cfg_cycle(1'b0, 1'b1, ofs[k], 32'h0);
      end
      repeat (4) cfg_cycle(1'b0, 1'b0, 8'h0, 32'h0);
      cmp_data(32'(wq.size() + rq.size()), 32'h0);
      complete_run();
   end
endmodule // meid_injector_test
`default_nettype wire
